// [rtl/uvpa_pkg.sv]
// Purpose: Shared constants and types for the UV memory programmer controller
// Assumes: 25 MHz ref_clk
// Notes: Times kept in their own units, cycle counts derived from them
package uvpa_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SMALL_WORDS = 1024;
  localparam int unsigned LARGE_WORDS = 2048;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned PULSE_US = 1000;
  localparam int unsigned PULSE_MIN_US = 100;
  localparam int unsigned GAP_US = 1;
  localparam int unsigned SETUP_US = 10;
  localparam int unsigned HOLD_NS = 1000;
  localparam int unsigned TOTAL_MS = 100;
  localparam int unsigned RECOVER_US = 10;
  localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int unsigned GAP_CYC = GAP_US * CLK_MHZ;
  localparam int unsigned SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int unsigned HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RECOVER_CYC = RECOVER_US * CLK_MHZ;
  localparam int unsigned LOOPS = (TOTAL_MS * 1000 + PULSE_US - 1) / PULSE_US;
  localparam int unsigned CNT_W = 20;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic select_program_enable;
    logic supply_program_enable;
    logic program_pulse;
  } uvpa_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic doe;
  } uvpa_data_t;
endpackage

// [rtl/uvpa_timer.sv]
// Purpose: Down counter for programming phase delays
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module uvpa_timer
#(
  parameter int unsigned W = 20
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (load)
      cnt_ff <= value;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - 1'b1;
  end

  assign done = (cnt_ff == '0);
endmodule
`default_nettype wire

// [rtl/uvpa_ctrl.sv]
// Purpose: Host-side read and programming controller for a UV-erasable memory
// Assumes: Inputs synchronous to ref_clk; pins modelled as logic levels
// Notes: Image supplied word by word on a request/data source port
`timescale 1ns/1ps
`default_nettype none
module uvpa_ctrl
  import uvpa_pkg::*;
#(
  parameter bit LARGE = 1'b0,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned LOOP_COUNT = LOOPS
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_ack,
  output logic [DATA_W-1:0] rd_data,
  input wire logic prog_start,
  output logic prog_busy,
  output logic prog_done,
  output logic [ADDR_W-1:0] img_addr,
  output logic img_req,
  input wire logic [DATA_W-1:0] img_data,
  output uvpa_pkg::uvpa_pins_t pins,
  output uvpa_pkg::uvpa_data_t bus_out,
  input wire logic [DATA_W-1:0] byte_data_pins
);
  typedef enum logic [3:0] {
    S_IDLE, S_RD_SEL, S_RD_WAIT, S_PE_SETUP, S_WORD_SETUP, S_PULSE, S_GAP,
    S_PE_HOLD, S_RELEASE, S_RECOVER
  } uvpa_state_t;

  localparam int unsigned RD_CYC = 12;
  localparam logic [ADDR_W-1:0] LAST_ADDR = LARGE ? ADDR_W'(LARGE_WORDS - 1)
                                                  : ADDR_W'(SMALL_WORDS - 1);

  uvpa_state_t state_ff;
  uvpa_state_t nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [15:0] loop_ff;
  logic [DATA_W-1:0] data_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic doe_ff;
  logic pe_ff;
  logic pulse_ff;
  logic sel_b_ff;
  logic done_ff;
  logic tload;
  logic [CNT_W-1:0] tval;
  logic tdone;
  logic last_word;
  logic last_loop;

  uvpa_timer #(.W(CNT_W)) u_timer
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(tload),
    .value(tval),
    .done(tdone)
  );

  assign last_word = (addr_ff == LAST_ADDR);
  assign last_loop = (loop_ff == 16'(LOOP_COUNT - 1));

  always_comb
  begin
    nxt_state = state_ff;
    tload = 1'b0;
    tval = '0;
    unique case (state_ff)
      S_IDLE:
        if (prog_start)
        begin
          nxt_state = S_PE_SETUP;
          tload = 1'b1;
          tval = CNT_W'(SETUP_CYC);
        end
        else if (rd_req)
        begin
          nxt_state = S_RD_SEL;
          tload = 1'b1;
          tval = CNT_W'(RD_CYC);
        end
      S_RD_SEL:
        if (tdone)
          nxt_state = S_RD_WAIT;
      S_RD_WAIT:
        nxt_state = S_IDLE;
      S_PE_SETUP:
        if (tdone)
        begin
          nxt_state = S_WORD_SETUP;
          tload = 1'b1;
          tval = CNT_W'(SETUP_CYC);
        end
      S_WORD_SETUP:
        if (tdone)
        begin
          nxt_state = S_PULSE;
          tload = 1'b1;
          // The timer spends one extra cycle at zero, so load one less to keep
          // the pulse within its upper bound
          tval = CNT_W'(PULSE_CYCLES - 1);
        end
      S_PULSE:
        if (tdone)
        begin
          nxt_state = S_GAP;
          tload = 1'b1;
          tval = CNT_W'(HOLD_CYC > GAP_CYC ? HOLD_CYC : GAP_CYC);
        end
      S_GAP:
        if (tdone)
        begin
          tload = 1'b1;
          if (last_word && last_loop)
          begin
            nxt_state = S_PE_HOLD;
            tval = CNT_W'(HOLD_CYC);
          end
          else
          begin
            nxt_state = S_WORD_SETUP;
            tval = CNT_W'(SETUP_CYC);
          end
        end
      S_PE_HOLD:
        if (tdone)
          nxt_state = S_RELEASE;
      S_RELEASE:
      begin
        nxt_state = S_RECOVER;
        tload = 1'b1;
        tval = CNT_W'(RECOVER_CYC);
      end
      S_RECOVER:
        if (tdone)
          nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= S_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Address: read address latched, program address walks and wraps
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      addr_ff <= '0;
    else if (state_ff == S_IDLE && prog_start)
      addr_ff <= '0;
    else if (state_ff == S_IDLE && rd_req)
      addr_ff <= LARGE ? rd_addr : {1'b0, rd_addr[ADDR_W-2:0]};
    else if (state_ff == S_GAP && tdone && !(last_word && last_loop))
      addr_ff <= last_word ? '0 : addr_ff + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      loop_ff <= '0;
    else if (state_ff == S_IDLE)
      loop_ff <= '0;
    else if (state_ff == S_GAP && tdone && last_word)
      loop_ff <= loop_ff + 1'b1;
  end

  // Image word fetched during setup so data is stable before the pulse
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_ff <= '1;
    else if (state_ff == S_WORD_SETUP)
      data_ff <= img_data;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      doe_ff <= 1'b0;
    else if (state_ff == S_PE_HOLD && tdone)
      doe_ff <= 1'b0;
    else if (state_ff == S_PE_SETUP && tdone)
      doe_ff <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      pe_ff <= 1'b0;
    else if (state_ff == S_IDLE && prog_start)
      pe_ff <= 1'b1;
    else if (state_ff == S_PE_HOLD && tdone)
      pe_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= (nxt_state == S_PULSE);
  end

  // Select low only for reads; in program mode only the large part's select pin carries the pulse
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_b_ff <= 1'b1;
    else
      sel_b_ff <= !(nxt_state == S_RD_SEL || nxt_state == S_RD_WAIT);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= '0;
    else if (state_ff == S_RD_SEL && tdone)
      rdata_ff <= byte_data_pins;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      done_ff <= 1'b0;
    else if (state_ff == S_IDLE && prog_start)
      done_ff <= 1'b0;
    else if (state_ff == S_RECOVER && tdone)
      done_ff <= 1'b1;
  end

  // Small part: select pin is the program enable at high level, pulse on its own pin.
  // Large part: supply pin carries program enable, select pin carries the pulse.
  always_comb
  begin
    pins.addr = addr_ff;
    pins.program_pulse = LARGE ? 1'b0 : pulse_ff;
    if (LARGE)
    begin
      pins.supply_program_enable = pe_ff;
      pins.select_program_enable = pe_ff ? pulse_ff : sel_b_ff;
    end
    else
    begin
      pins.supply_program_enable = 1'b0;
      pins.select_program_enable = pe_ff | sel_b_ff;
    end
  end

  assign bus_out.dout = data_ff;
  assign bus_out.doe = doe_ff;
  assign img_addr = addr_ff;
  assign img_req = (state_ff == S_WORD_SETUP);
  assign rd_ack = (state_ff == S_RD_WAIT);
  assign rd_data = rdata_ff;
  assign prog_busy = (state_ff != S_IDLE) && (state_ff != S_RD_SEL)
                     && (state_ff != S_RD_WAIT);
  assign prog_done = done_ff;
endmodule
`default_nettype wire

// [sim/uvpa_mem_model.sv]
// Purpose: Behavioural small-variant memory facing the controller pins
// Assumes: 1024 words; select high or supply pin high means program mode
// Notes: Outputs float as the inverted word so a stale byte never looks valid
`timescale 1ns/1ps
`default_nettype none
module uvpa_mem_model
  import uvpa_pkg::*;
(
  input wire uvpa_pkg::uvpa_pins_t pins,
  input wire uvpa_pkg::uvpa_data_t bus_out,
  output logic [DATA_W-1:0] byte_data_pins
);
  logic [DATA_W-1:0] mem [0:SMALL_WORDS-1];
  logic [9:0] waddr;
  logic pgm_pulse;
  assign waddr = pins.addr[9:0];
  // With the supply pin in program mode the select pin carries the pulse
  assign pgm_pulse = pins.supply_program_enable ? pins.select_program_enable
    : pins.program_pulse;
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hff;
  end
  // Pulse only clears bits, erasure is the only way back
  always @(posedge pgm_pulse)
  begin
    if ((pins.select_program_enable || pins.supply_program_enable) && bus_out.doe)
      mem[waddr] = mem[waddr] & bus_out.dout;
  end
  assign byte_data_pins = (!pins.select_program_enable && !pins.program_pulse
    && !pins.supply_program_enable) ? mem[waddr] : ~mem[waddr];
endmodule
`default_nettype wire

// [sim/uvpa_ctrl_chk.sv]
// Purpose: Pin and handshake assertions for the controller
// Assumes: Small variant, single clock domain
// Notes: Recovery after a full sequence is not reached by the bench
`timescale 1ns/1ps
`default_nettype none
module uvpa_ctrl_chk
  import uvpa_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = 4
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rd_ack,
  input wire logic prog_busy,
  input wire logic [ADDR_W-1:0] img_addr,
  input wire uvpa_pkg::uvpa_pins_t pins,
  input wire uvpa_pkg::uvpa_data_t bus_out
);
  logic [19:0] pw_cnt_ff;
  logic [7:0] gap_cnt_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      pw_cnt_ff <= '0;
    else
      pw_cnt_ff <= pins.program_pulse ? pw_cnt_ff + 20'h1 : 20'h0;
  end
  // Saturates so a long idle never wraps below the gap figure
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      gap_cnt_ff <= 8'hff;
    else if (pins.program_pulse)
      gap_cnt_ff <= 8'h00;
    else if (gap_cnt_ff != 8'hff)
      gap_cnt_ff <= gap_cnt_ff + 8'h01;
  end
  sequence s_read_start;
    $fell(pins.select_program_enable) && !prog_busy;
  endsequence
  sequence s_pulse_on;
    $rose(pins.program_pulse);
  endsequence
  AST_READ_ACK: assert property (s_read_start |-> ##[12:14] rd_ack)
    else $error("read not answered in time");
  AST_PULSE_IDLE: assert property (pins.program_pulse |-> prog_busy)
    else $error("pulse outside programming");
  AST_PE_HELD: assert property (pins.program_pulse |-> pins.select_program_enable)
    else $error("pulse without program enable");
  AST_SETUP: assert property (s_pulse_on |-> $past(bus_out.doe) && $stable(pins.addr))
    else $error("pulse without data setup");
  AST_WIDTH: assert property ($fell(pins.program_pulse) |-> pw_cnt_ff == PULSE_CYCLES)
    else $error("pulse width wrong");
  AST_GAP: assert property (
    $changed(pins.addr) && pins.select_program_enable && $past(pins.select_program_enable)
    |-> gap_cnt_ff >= 8'd24)
    else $error("address moved too soon after pulse");
  AST_DOE_PE: assert property (bus_out.doe |-> pins.select_program_enable && !rd_ack)
    else $error("data driven outside program mode");
  AST_DOE_ADDR: assert property ($fell(bus_out.doe) |-> $stable(pins.addr))
    else $error("address moved as data released");
  AST_SEQ: assert property (
    $changed(img_addr) && prog_busy && $past(prog_busy)
    |-> img_addr == 11'h0 || img_addr == $past(img_addr) + 11'h1)
    else $error("program address not sequential");
endmodule
bind uvpa_ctrl uvpa_ctrl_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_uvpa_ctrl_chk (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .rd_ack(rd_ack),
  .prog_busy(prog_busy),
  .img_addr(img_addr),
  .pins(pins),
  .bus_out(bus_out)
);
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the memory controller
// Assumes: Small variant, short pulse, two loops
// Notes: Programming is cut short by reset to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uvpa_pkg::*;
  logic ref_clk, rst_b, rd_req, prog_start, rd_ack, prog_busy, img_req, prog_done;
  logic [ADDR_W-1:0] rd_addr, img_addr;
  logic [DATA_W-1:0] rd_data, img_data, byte_data_pins, key;
  uvpa_pins_t pins;
  uvpa_data_t bus_out;
  int bad_count, n_checks, cyc;
  uvpa_ctrl #(.LARGE(1'b0), .PULSE_CYCLES(4), .LOOP_COUNT(2)) i_uvpa_ctrl (
    .ref_clk(ref_clk), .rst_b(rst_b), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .prog_start(prog_start),
    .prog_busy(prog_busy), .prog_done(prog_done), .img_addr(img_addr), .img_req(img_req),
    .img_data(img_data), .pins(pins), .bus_out(bus_out),
    .byte_data_pins(byte_data_pins));
  uvpa_mem_model i_uvpa_mem_model (.pins(pins), .bus_out(bus_out),
    .byte_data_pins(byte_data_pins));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    img_data <= img_addr[7:0] ^ key;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    rd_addr <= a;
    rd_req <= 1'b1;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    for (int i = 0; i < 40 && rd_ack !== 1'b1; i++)
      @(posedge ref_clk);
    cmp(rd_data, exp);
  endtask
  // Reset lands while word two is set up, so only words zero and one are pulsed
  task automatic prog_abort(input logic [7:0] k);
    key <= k;
    prog_start <= 1'b1;
    @(posedge ref_clk);
    prog_start <= 1'b0;
    for (int i = 0; i < 2000 && img_addr !== 11'h2; i++)
      @(posedge ref_clk);
    cmp({7'h0, prog_busy}, 8'h01);
    cmp({7'h0, img_req}, 8'h01);
    cmp({7'h0, prog_done}, 8'h00);
    rst_b <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic t_erased();
    rd(11'h000, 8'hff);
    rd(11'h3ff, 8'hff);
  endtask
  task automatic t_first_pass();
    prog_abort(8'h5a);
    rd(11'h000, 8'h5a);
    rd(11'h001, 8'h5b);
    rd(11'h002, 8'hff);
    rd(11'h401, 8'h5b);
  endtask
  task automatic t_second_pass();
    prog_abort(8'hc3);
    rd(11'h000, 8'h5a & 8'hc3);
    rd(11'h001, 8'h5b & 8'hc2);
  endtask
  initial
  begin
    rst_b = 1'b0;
    rd_req = 1'b0;
    prog_start = 1'b0;
    rd_addr = '0;
    key = 8'h00;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_erased();
    t_first_pass();
    t_second_pass();
    summarize();
  end
endmodule
`default_nettype wire
